//--- src/flow_exec_cfg.svh
// Constants for the branch, skip, bit and shift execution unit.
`ifndef FLOW_EXEC_CFG_SVH
`define FLOW_EXEC_CFG_SVH

// Datapath widths.
`define DATA_W 8
`define PC_W 16
`define DISP_W 7
`define OP_W 6

// Positions of the flags inside the status flags register.
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// Reset values.
`define FLAGS_RST 8'h00
`define PC_RST 16'h0000
`define DATA_RST 8'h00
`define CNT_RST 2'h0
`define READY_RST 1'b1

// Cycle counts and program counter steps.
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define PC_STEP_ONE 16'h0001
`define PC_STEP_SKIP_ONE 16'h0002
`define PC_STEP_SKIP_TWO 16'h0003
`define DATA_ZERO 8'h00
`define BIT_ONE 8'h01

`endif

//--- src/flow_exec_pkg.sv
// Types shared by the branch, skip, bit and shift execution unit.
package flow_exec_pkg;

  typedef enum logic [5:0] {
    OP_SKIP_REG_BIT_SET = 6'b000000,
    OP_SKIP_IO_BIT_CLEAR = 6'b000001,
    OP_SKIP_IO_BIT_SET = 6'b000010,
    OP_BRANCH_FLAG_INDEX_SET = 6'b000011,
    OP_BRANCH_FLAG_INDEX_CLEAR = 6'b000100,
    OP_BRANCH_EQUAL = 6'b000101,
    OP_BRANCH_NOT_EQUAL = 6'b000110,
    OP_BRANCH_CARRY_SET = 6'b000111,
    OP_BRANCH_CARRY_CLEAR = 6'b001000,
    OP_BRANCH_SAME_OR_HIGHER = 6'b001001,
    OP_BRANCH_LOWER = 6'b001010,
    OP_BRANCH_MINUS = 6'b001011,
    OP_BRANCH_PLUS = 6'b001100,
    OP_BRANCH_SIGNED_GE = 6'b001101,
    OP_BRANCH_SIGNED_LT = 6'b001110,
    OP_BRANCH_HALF_CARRY_SET = 6'b001111,
    OP_BRANCH_HALF_CARRY_CLEAR = 6'b010000,
    OP_BRANCH_TRANSFER_BIT_SET = 6'b010001,
    OP_BRANCH_TRANSFER_BIT_CLEAR = 6'b010010,
    OP_BRANCH_OVERFLOW_SET = 6'b010011,
    OP_BRANCH_OVERFLOW_CLEAR = 6'b010100,
    OP_BRANCH_IRQ_ENABLED = 6'b010101,
    OP_BRANCH_IRQ_DISABLED = 6'b010110,
    OP_IO_BIT_SET = 6'b010111,
    OP_IO_BIT_CLEAR = 6'b011000,
    OP_SHIFT_LEFT_LOGICAL = 6'b011001,
    OP_SHIFT_RIGHT_LOGICAL = 6'b011010,
    OP_ROTATE_LEFT_CARRY = 6'b011011,
    OP_ROTATE_RIGHT_CARRY = 6'b011100,
    OP_SHIFT_RIGHT_ARITH = 6'b011101,
    OP_BIT_TO_TRANSFER_FLAG = 6'b011110,
    OP_TRANSFER_FLAG_TO_BIT = 6'b011111,
    OP_CARRY_FORCE_ONE = 6'b100000,
    OP_CARRY_FORCE_ZERO = 6'b100001
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_t;

endpackage

//--- src/flow_exec_unit.sv
// Execution unit for skips, branches, I/O bit writes, shifts and flag moves.
// Overview of operation
// RULE_01 - Register bit set skips next instruction
// RULE_02 - I/O bit clear skips next instruction
// RULE_03 - I/O bit set skips; skips keep flags
// RULE_04 - Indexed flag branches: PC plus k plus one
// RULE_05 - Zero and carry branches, flags unchanged
// RULE_06 - Same-or-higher is carry clear; lower carry set
// RULE_07 - Signed branches use N xor V; N alone
// RULE_08 - Half-carry branches set or clear
// RULE_09 - Transfer bit branches set or clear
// RULE_10 - Overflow branches set or clear
// RULE_11 - Interrupt enable branches on flag I
// RULE_12 - I/O bit set/clear, two cycles, no flags
// RULE_13 - Shift left, shift right, rotate left
// RULE_14 - Rotate right through carry, flags updated
// RULE_15 - Arithmetic right shift keeps bit seven
// RULE_16 - Bit store to T, bit load from T
// RULE_17 - Force carry one or zero
// RULE_18 - Skip one or two words, extra cycles
// RULE_19 - Displacement is signed two's complement
`timescale 1ns/1ps
`default_nettype none
`include "flow_exec_cfg.svh"

module flow_exec_unit
  import flow_exec_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Instruction from decode.
  input wire logic CMD_VALID,
  input wire op_t CMD_OP,
  input wire logic [`PC_W-1:0] CMD_PC,
  input wire logic [`DATA_W-1:0] CMD_REG,
  input wire logic [`DATA_W-1:0] CMD_IO,
  input wire logic [2:0] CMD_BIT,
  input wire logic [`DISP_W-1:0] CMD_K,
  input wire logic CMD_NEXT_TWO_WORD,
  output logic CMD_READY,
  // Status flags loaded by other instruction classes.
  input wire logic FLAGS_LOAD,
  input wire logic [`DATA_W-1:0] FLAGS_IN,
  output logic [`DATA_W-1:0] STATUS_FLAGS,
  // Results.
  output logic DONE,
  output logic [`PC_W-1:0] PC_NEXT,
  output logic REG_WE,
  output logic [`DATA_W-1:0] REG_DATA,
  output logic IO_WE,
  output logic [`DATA_W-1:0] IO_DATA
);

  state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic [`DATA_W-1:0] flags_q, flags_d;
  logic [`PC_W-1:0] pc_q, pc_d;
  logic reg_we_q, reg_we_d;
  logic [`DATA_W-1:0] reg_data_q, reg_data_d;
  logic io_we_q, io_we_d;
  logic [`DATA_W-1:0] io_data_q, io_data_d;
  logic reg_pend_q, reg_pend_d;
  logic io_pend_q, io_pend_d;

  logic take;
  logic is_skip;
  logic is_jump;
  logic is_shift;
  logic cond;
  logic carry_new;
  logic reg_wr;
  logic io_wr;
  logic [1:0] ncyc;
  logic [`DATA_W-1:0] res;
  logic [`DATA_W-1:0] io_res;
  logic [`DATA_W-1:0] fl;
  logic [`DATA_W-1:0] bit_mask;
  logic [`PC_W-1:0] pc_new;
  logic [`PC_W-1:0] disp;

  assign take = CMD_VALID && ready_q;

  always_comb begin
    is_skip = CMD_OP inside {OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
    is_jump = CMD_OP inside {[OP_BRANCH_FLAG_INDEX_SET:OP_BRANCH_IRQ_DISABLED]};
    is_shift = 1'b0;
    cond = 1'b0;
    carry_new = flags_q[`FLAG_C];
    reg_wr = 1'b0;
    io_wr = 1'b0;
    res = CMD_REG;
    io_res = CMD_IO;
    fl = flags_q;
    ncyc = `CYC_ONE;
    bit_mask = `BIT_ONE << CMD_BIT;
    // The displacement is sign extended so that branches reach backwards too.
    disp = {{(`PC_W-`DISP_W){CMD_K[`DISP_W-1]}}, CMD_K}; // RULE_19
    pc_new = CMD_PC + `PC_STEP_ONE;
    unique case (CMD_OP)
      OP_SKIP_REG_BIT_SET: cond = CMD_REG[CMD_BIT]; // RULE_01
      OP_SKIP_IO_BIT_CLEAR: cond = !CMD_IO[CMD_BIT]; // RULE_02
      OP_SKIP_IO_BIT_SET: cond = CMD_IO[CMD_BIT]; // RULE_03
      OP_BRANCH_FLAG_INDEX_SET: cond = flags_q[CMD_BIT]; // RULE_04
      OP_BRANCH_FLAG_INDEX_CLEAR: cond = !flags_q[CMD_BIT]; // RULE_04
      OP_BRANCH_EQUAL: cond = flags_q[`FLAG_Z]; // RULE_05
      OP_BRANCH_NOT_EQUAL: cond = !flags_q[`FLAG_Z]; // RULE_05
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: cond = flags_q[`FLAG_C]; // RULE_06
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: cond = !flags_q[`FLAG_C]; // RULE_06
      OP_BRANCH_MINUS: cond = flags_q[`FLAG_N]; // RULE_07
      OP_BRANCH_PLUS: cond = !flags_q[`FLAG_N]; // RULE_07
      OP_BRANCH_SIGNED_GE: cond = !(flags_q[`FLAG_N] ^ flags_q[`FLAG_V]); // RULE_07
      OP_BRANCH_SIGNED_LT: cond = flags_q[`FLAG_N] ^ flags_q[`FLAG_V]; // RULE_07
      OP_BRANCH_HALF_CARRY_SET: cond = flags_q[`FLAG_H]; // RULE_08
      OP_BRANCH_HALF_CARRY_CLEAR: cond = !flags_q[`FLAG_H]; // RULE_08
      OP_BRANCH_TRANSFER_BIT_SET: cond = flags_q[`FLAG_T]; // RULE_09
      OP_BRANCH_TRANSFER_BIT_CLEAR: cond = !flags_q[`FLAG_T]; // RULE_09
      OP_BRANCH_OVERFLOW_SET: cond = flags_q[`FLAG_V]; // RULE_10
      OP_BRANCH_OVERFLOW_CLEAR: cond = !flags_q[`FLAG_V]; // RULE_10
      OP_BRANCH_IRQ_ENABLED: cond = flags_q[`FLAG_I]; // RULE_11
      OP_BRANCH_IRQ_DISABLED: cond = !flags_q[`FLAG_I]; // RULE_11
      OP_IO_BIT_SET: begin
        io_wr = 1'b1;
        io_res = CMD_IO | bit_mask; // RULE_12
        ncyc = `CYC_TWO;
      end
      OP_IO_BIT_CLEAR: begin
        io_wr = 1'b1;
        io_res = CMD_IO & ~bit_mask; // RULE_12
        ncyc = `CYC_TWO;
      end
      OP_SHIFT_LEFT_LOGICAL: begin
        is_shift = 1'b1;
        res = {CMD_REG[6:0], 1'b0}; // RULE_13
        carry_new = CMD_REG[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        is_shift = 1'b1;
        res = {1'b0, CMD_REG[7:1]}; // RULE_13
        carry_new = CMD_REG[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        is_shift = 1'b1;
        res = {CMD_REG[6:0], flags_q[`FLAG_C]}; // RULE_13
        carry_new = CMD_REG[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        is_shift = 1'b1;
        res = {flags_q[`FLAG_C], CMD_REG[7:1]}; // RULE_14
        carry_new = CMD_REG[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        is_shift = 1'b1;
        res = {CMD_REG[7], CMD_REG[7:1]}; // RULE_15
        carry_new = CMD_REG[0];
      end
      OP_BIT_TO_TRANSFER_FLAG: begin
        fl[`FLAG_T] = CMD_REG[CMD_BIT]; // RULE_16
      end
      OP_TRANSFER_FLAG_TO_BIT: begin
        reg_wr = 1'b1;
        res = flags_q[`FLAG_T] ? (CMD_REG | bit_mask) : (CMD_REG & ~bit_mask); // RULE_16
      end
      OP_CARRY_FORCE_ONE: begin
        fl[`FLAG_C] = 1'b1; // RULE_17
      end
      OP_CARRY_FORCE_ZERO: begin
        fl[`FLAG_C] = 1'b0; // RULE_17
      end
      default: begin
      end
    endcase
    // Shifts share one flag update; S is left alone since only Z, C, N and V change.
    if (is_shift) begin
      reg_wr = 1'b1;
      fl[`FLAG_C] = carry_new; // RULE_14
      fl[`FLAG_Z] = (res == `DATA_ZERO);
      fl[`FLAG_N] = res[7];
      fl[`FLAG_V] = res[7] ^ carry_new; // RULE_15
    end
    if (is_skip && cond) begin
      // Each skipped word costs one cycle on top of the base cycle.
      pc_new = CMD_PC + (CMD_NEXT_TWO_WORD ? `PC_STEP_SKIP_TWO : `PC_STEP_SKIP_ONE); // RULE_18
      ncyc = CMD_NEXT_TWO_WORD ? `CYC_THREE : `CYC_TWO; // RULE_18
    end
    if (is_jump && cond) begin
      pc_new = CMD_PC + disp + `PC_STEP_ONE; // RULE_04
      ncyc = `CYC_TWO; // RULE_10
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ready_d = ready_q;
    done_d = 1'b0;
    reg_we_d = 1'b0;
    io_we_d = 1'b0;
    flags_d = flags_q;
    pc_d = pc_q;
    reg_data_d = reg_data_q;
    io_data_d = io_data_q;
    reg_pend_d = reg_pend_q;
    io_pend_d = io_pend_q;
    // An outside load of the flags yields to an instruction taken in the same cycle.
    if (FLAGS_LOAD && !take) begin
      flags_d = FLAGS_IN;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          flags_d = fl; // RULE_03
          pc_d = pc_new;
          reg_data_d = res;
          io_data_d = io_res;
          if (ncyc == `CYC_ONE) begin
            done_d = 1'b1;
            reg_we_d = reg_wr;
            io_we_d = io_wr;
          end else begin
            state_d = ST_WAIT;
            ready_d = 1'b0;
            cnt_d = ncyc - `CYC_ONE;
            reg_pend_d = reg_wr;
            io_pend_d = io_wr;
          end
        end
      end
      ST_WAIT: begin
        if (cnt_q == `CYC_ONE) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
          done_d = 1'b1;
          reg_we_d = reg_pend_q;
          io_we_d = io_pend_q; // RULE_12
        end else begin
          cnt_d = cnt_q - `CYC_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      cnt_q <= `CNT_RST;
      ready_q <= `READY_RST;
      done_q <= 1'b0;
      flags_q <= `FLAGS_RST;
      pc_q <= `PC_RST;
      reg_we_q <= 1'b0;
      reg_data_q <= `DATA_RST;
      io_we_q <= 1'b0;
      io_data_q <= `DATA_RST;
      reg_pend_q <= 1'b0;
      io_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      done_q <= done_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      reg_we_q <= reg_we_d;
      reg_data_q <= reg_data_d;
      io_we_q <= io_we_d;
      io_data_q <= io_data_d;
      reg_pend_q <= reg_pend_d;
      io_pend_q <= io_pend_d;
    end
  end

  assign CMD_READY = ready_q;
  assign DONE = done_q;
  assign STATUS_FLAGS = flags_q;
  assign PC_NEXT = pc_q;
  assign REG_WE = reg_we_q;
  assign REG_DATA = reg_data_q;
  assign IO_WE = io_we_q;
  assign IO_DATA = io_data_q;

  a_skip_reg_pc: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_01
    take && CMD_OP == OP_SKIP_REG_BIT_SET && CMD_REG[CMD_BIT] && !CMD_NEXT_TWO_WORD
    |=> PC_NEXT == $past(CMD_PC) + `PC_STEP_SKIP_ONE ##1 DONE)
    else $error("register bit skip did not advance by two in two cycles");

  a_skip_io_two: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_02
    take && CMD_OP == OP_SKIP_IO_BIT_CLEAR && !CMD_IO[CMD_BIT] && CMD_NEXT_TWO_WORD
    |=> (PC_NEXT == $past(CMD_PC) + `PC_STEP_SKIP_TWO) && !DONE ##1 !DONE ##1 DONE)
    else $error("I/O clear skip over two words mistimed");

  a_skip_keep_flags: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_03
    take && CMD_OP == OP_SKIP_IO_BIT_SET |=> STATUS_FLAGS == $past(STATUS_FLAGS))
    else $error("skip changed a status flag");

  a_branch_not_taken: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_04
    take && CMD_OP == OP_BRANCH_FLAG_INDEX_SET && !STATUS_FLAGS[CMD_BIT]
    |=> DONE && CMD_READY && PC_NEXT == $past(CMD_PC) + `PC_STEP_ONE)
    else $error("untaken branch not one cycle");

  a_branch_ge_target: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_07
    take && CMD_OP == OP_BRANCH_SIGNED_GE && STATUS_FLAGS[`FLAG_N] == STATUS_FLAGS[`FLAG_V]
    |=> !DONE && PC_NEXT == $past(CMD_PC)
    + {{(`PC_W-`DISP_W){$past(CMD_K[`DISP_W-1])}}, $past(CMD_K)} + `PC_STEP_ONE
    ##1 DONE)
    else $error("signed branch target or timing wrong");

  a_io_set_bit: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_12
    take && CMD_OP == OP_IO_BIT_SET
    |=> IO_DATA[$past(CMD_BIT)] && !IO_WE && STATUS_FLAGS == $past(STATUS_FLAGS)
    ##1 IO_WE && DONE)
    else $error("I/O bit set wrong");

  a_ror_carry: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_14
    take && CMD_OP == OP_ROTATE_RIGHT_CARRY
    |=> REG_WE && REG_DATA[7] == $past(STATUS_FLAGS[`FLAG_C])
    && STATUS_FLAGS[`FLAG_C] == $past(CMD_REG[0]))
    else $error("rotate right through carry wrong");

  a_asr_sign_kept: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_15
    take && CMD_OP == OP_SHIFT_RIGHT_ARITH
    |=> REG_DATA[7] == $past(CMD_REG[7]) && REG_DATA[6] == $past(CMD_REG[7]))
    else $error("arithmetic shift lost the sign bit");

  a_carry_force: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_17
    take && CMD_OP == OP_CARRY_FORCE_ONE
    |=> STATUS_FLAGS[`FLAG_C] && STATUS_FLAGS[7:1] == $past(STATUS_FLAGS[7:1]))
    else $error("carry force touched other flags");

endmodule

`default_nettype wire

//--- sim/flow_exec_unit_tb.sv
// Self-checking testbench for the branch, skip, bit and shift execution unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module branch_skip_bit_shift_unit_tb_top import flow_exec_pkg::*;;
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic CMD_VALID = 1'b0;
  op_t CMD_OP = OP_SKIP_REG_BIT_SET;
  logic [15:0] CMD_PC = 16'h0100;
  logic [7:0] CMD_REG = 8'h00;
  logic [7:0] CMD_IO = 8'h00;
  logic [2:0] CMD_BIT = 3'h0;
  logic [6:0] CMD_K = 7'h00;
  logic CMD_NEXT_TWO_WORD = 1'b0;
  logic FLAGS_LOAD = 1'b0;
  logic [7:0] FLAGS_IN = 8'h00;
  logic CMD_READY, DONE, REG_WE, IO_WE;
  logic [7:0] STATUS_FLAGS, REG_DATA, IO_DATA;
  logic [15:0] PC_NEXT;
  int errors = 0;
  int cmp_count = 0;
  int cyc;
  logic rwe, iwe;

  flow_exec_unit u_dut (.CLK_SYS, .NRST, .CMD_VALID, .CMD_OP, .CMD_PC, .CMD_REG, .CMD_IO,
    .CMD_BIT, .CMD_K, .CMD_NEXT_TWO_WORD, .CMD_READY, .FLAGS_LOAD, .FLAGS_IN, .STATUS_FLAGS,
    .DONE, .PC_NEXT, .REG_WE, .REG_DATA, .IO_WE, .IO_DATA);

  initial begin
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic load_flags(input logic [7:0] f);
    FLAGS_IN = f;
    FLAGS_LOAD = 1'b1;
    @(posedge CLK_SYS);
    #1;
    FLAGS_LOAD = 1'b0;
    `CHK("flags_load", f, STATUS_FLAGS)
  endtask

  // Issues one instruction and counts cycles up to DONE; the write strobes
  // are captured in the DONE cycle because they stand for that cycle only.
  task automatic run(input op_t op, input logic [7:0] r, io, input logic [2:0] b,
      input logic [6:0] k, input logic two, input logic [15:0] epc, input int ecyc);
    `CHK("ready", 1'b1, CMD_READY)
    CMD_OP = op;
    CMD_REG = r;
    CMD_IO = io;
    CMD_BIT = b;
    CMD_K = k;
    CMD_NEXT_TWO_WORD = two;
    CMD_VALID = 1'b1;
    @(posedge CLK_SYS);
    #1;
    CMD_VALID = 1'b0;
    cyc = 1;
    while (DONE !== 1'b1 && cyc < 6) begin
      @(posedge CLK_SYS);
      #1;
      cyc++;
    end
    rwe = REG_WE;
    iwe = IO_WE;
    `CHK("pc_next", epc, PC_NEXT)
    `CHK("cycles", ecyc, cyc)
  endtask

  task automatic t_skips();
    load_flags(8'hA5);
    run(OP_SKIP_REG_BIT_SET, 8'h08, 8'h00, 3'h3, 7'h00, 1'b0, 16'h0102, 2);
    run(OP_SKIP_REG_BIT_SET, 8'h08, 8'h00, 3'h3, 7'h00, 1'b1, 16'h0103, 3);
    run(OP_SKIP_REG_BIT_SET, 8'hF7, 8'h00, 3'h3, 7'h00, 1'b1, 16'h0101, 1);
    run(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'hBF, 3'h6, 7'h00, 1'b1, 16'h0103, 3);
    run(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h40, 3'h6, 7'h00, 1'b0, 16'h0101, 1);
    run(OP_SKIP_IO_BIT_SET, 8'h00, 8'h80, 3'h7, 7'h00, 1'b0, 16'h0102, 2);
    run(OP_SKIP_IO_BIT_SET, 8'hFF, 8'h7F, 3'h7, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("skip_flags", 8'hA5, STATUS_FLAGS)
  endtask

  function automatic logic taken(input op_t op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      OP_BRANCH_FLAG_INDEX_SET: return f[s];
      OP_BRANCH_FLAG_INDEX_CLEAR: return !f[s];
      OP_BRANCH_EQUAL: return f[1];
      OP_BRANCH_NOT_EQUAL: return !f[1];
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: return f[0];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: return !f[0];
      OP_BRANCH_MINUS: return f[2];
      OP_BRANCH_PLUS: return !f[2];
      OP_BRANCH_SIGNED_GE: return !(f[2] ^ f[3]);
      OP_BRANCH_SIGNED_LT: return f[2] ^ f[3];
      OP_BRANCH_HALF_CARRY_SET: return f[5];
      OP_BRANCH_HALF_CARRY_CLEAR: return !f[5];
      OP_BRANCH_TRANSFER_BIT_SET: return f[6];
      OP_BRANCH_TRANSFER_BIT_CLEAR: return !f[6];
      OP_BRANCH_OVERFLOW_SET: return f[3];
      OP_BRANCH_OVERFLOW_CLEAR: return !f[3];
      OP_BRANCH_IRQ_ENABLED: return f[7];
      default: return !f[7];
    endcase
  endfunction

  // Every branch under flag patterns that set and clear each flag, with
  // forward and backward displacements.
  task automatic t_branches();
    logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
    logic [6:0] k;
    logic [2:0] s;
    logic t;
    for (int i = 0; i < 4; i++) begin
      load_flags(pat[i]);
      for (int o = OP_BRANCH_FLAG_INDEX_SET; o <= OP_BRANCH_IRQ_DISABLED; o++) begin
        k = (o % 2 == 1) ? 7'h7B : 7'h05;
        s = 3'(o + i);
        t = taken(op_t'(o), pat[i], s);
        run(op_t'(o), 8'h00, 8'h00, s, k, 1'b0, t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101,
            t ? 2 : 1);
        `CHK("branch_writes", 2'b00, {rwe, iwe})
      end
      `CHK("branch_flags", pat[i], STATUS_FLAGS)
    end
  endtask

  task automatic t_io_bits();
    load_flags(8'h3C);
    run(OP_IO_BIT_SET, 8'h00, 8'h00, 3'h5, 7'h00, 1'b0, 16'h0101, 2);
    `CHK("io_set", 9'h120, {iwe, IO_DATA})
    run(OP_IO_BIT_CLEAR, 8'h00, 8'hFF, 3'h0, 7'h00, 1'b0, 16'h0101, 2);
    `CHK("io_clear", 9'h1FE, {iwe, IO_DATA})
    `CHK("io_flags", 8'h3C, STATUS_FLAGS)
  endtask

  // Old V, N and Z are preloaded high so that a flag left stale shows up.
  task automatic shift_chk(input op_t op, input logic [7:0] v, input logic cin,
      input logic [7:0] res, input logic cout);
    logic [7:0] f;
    f = {4'hD, res[7] ^ cout, res[7], res == 8'h00, cout};
    load_flags({4'hD, 3'h7, cin});
    run(op, v, 8'h00, 3'h0, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("shift_result", 9'h100 | res, {rwe, REG_DATA})
    `CHK("shift_flags", f, STATUS_FLAGS)
  endtask

  task automatic t_shifts();
    shift_chk(OP_SHIFT_LEFT_LOGICAL, 8'h81, 1'b1, 8'h02, 1'b1);
    shift_chk(OP_SHIFT_RIGHT_LOGICAL, 8'h01, 1'b1, 8'h00, 1'b1);
    shift_chk(OP_SHIFT_RIGHT_LOGICAL, 8'h80, 1'b0, 8'h40, 1'b0);
    shift_chk(OP_ROTATE_LEFT_CARRY, 8'h80, 1'b1, 8'h01, 1'b1);
    shift_chk(OP_ROTATE_LEFT_CARRY, 8'h41, 1'b0, 8'h82, 1'b0);
    shift_chk(OP_ROTATE_RIGHT_CARRY, 8'h02, 1'b1, 8'h81, 1'b0);
    shift_chk(OP_SHIFT_RIGHT_ARITH, 8'h81, 1'b0, 8'hC0, 1'b1);
  endtask

  task automatic t_bits();
    load_flags(8'h00);
    run(OP_BIT_TO_TRANSFER_FLAG, 8'h10, 8'h00, 3'h4, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("bit_store", 8'h40, STATUS_FLAGS)
    run(OP_TRANSFER_FLAG_TO_BIT, 8'h00, 8'h00, 3'h3, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("bit_load_one", 9'h108, {rwe, REG_DATA})
    load_flags(8'hBF);
    run(OP_TRANSFER_FLAG_TO_BIT, 8'hFF, 8'h00, 3'h7, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("bit_load_zero", 9'h17F, {rwe, REG_DATA})
    `CHK("bit_load_flags", 8'hBF, STATUS_FLAGS)
    run(OP_CARRY_FORCE_ZERO, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("carry_zero", 8'hBE, STATUS_FLAGS)
    run(OP_CARRY_FORCE_ONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 16'h0101, 1);
    `CHK("carry_one", 8'hBF, STATUS_FLAGS)
  endtask

  initial begin
    #(25 * 5000);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge CLK_SYS);
    #1;
    NRST = 1'b1;
    `CHK("rst_ready", 1'b1, CMD_READY)
    `CHK("rst_state", 27'h0, {DONE, REG_WE, IO_WE, PC_NEXT, STATUS_FLAGS})
    t_skips();
    t_branches();
    t_io_bits();
    t_shifts();
    t_bits();
    report_and_stop();
  end
endmodule

`default_nettype wire
